// [hw/gpl_top.sv]
// Behaviour
// - first open-drain port latch at bank 2, location 71H.
// - second open-drain port latch at bank 2, location 72.
// - push-pull port latch at bank 0, 72H; cleared to 0 at reset.
// - bidirectional port switches direction for all four bits together.
// - bidirectional direction held in bit 0 of register-file 27H.
// - bidirectional port output latch at bank 1, location 72.
// - bidirectional port forced to input at power-up, clock stop, CE reset.
// - input-only port pin levels read at 73H; pins double as analog.
// - 4-bit analog converter, successive comparison stepped by program.
// - remote input filtered against noise before edge detection.
// - edge flag clear requests on rising edge, set on falling edge.
// - CE reset clears edge flag, selecting rising-edge detection.
// - CE low-to-high pulses ce_reset and forces the bidirectional port to input.
`timescale 1ns/1ps
`default_nettype none
module gpl_top (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // chip enable pin and oscillator stop
  input wire logic ce_pin,
  input wire logic osc_stopped,
  output logic ce_reset,
  // cpu data memory
  input wire gpl_pkg::gpl_dm_req_t dm_req,
  output logic [gpl_pkg::NIB_W-1:0] dm_rdata,
  output logic dm_hit,
  // cpu register file
  input wire gpl_pkg::gpl_rf_req_t rf_req,
  output logic [gpl_pkg::NIB_W-1:0] rf_rdata,
  output logic rf_hit,
  // output ports
  output logic [gpl_pkg::NIB_W-1:0] push_pull_out_port,
  output gpl_pkg::gpl_pin_t open_drain_out_port_b,
  output gpl_pkg::gpl_pin_t open_drain_out_port_c,
  // bidirectional and input ports
  input wire logic [gpl_pkg::NIB_W-1:0] nibble_bidir_port_in,
  output gpl_pkg::gpl_pin_t nibble_bidir_port,
  input wire logic [gpl_pkg::NIB_W-1:0] input_only_port,
  // analog converter
  input wire logic adc_cmp_pin,
  output logic [gpl_pkg::NIB_W-1:0] adc_ref,
  output logic [2:0] adc_chan,
  // remote-control interrupt
  input wire logic remote_ctl_irq_in,
  output logic remote_ctl_irq
);
  import gpl_pkg::*;

  function automatic logic dm_at(gpl_dm_req_t r, logic [BANK_W-1:0] b,
                                 logic [ADDR_W-1:0] a);
    dm_at = (r.bank == b) && (r.addr == a);
  endfunction

  // synchronised pins
  logic ce_lvl, rmc_lvl, cmp_lvl;
  logic [NIB_W-1:0] bidir_lvl, in_lvl;

  gpl_pin_sync #(.W(1)) u_ce_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(ce_pin),
    .level(ce_lvl)
  );

  gpl_pin_sync #(.W(1)) u_rmc_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(remote_ctl_irq_in),
    .level(rmc_lvl)
  );

  gpl_pin_sync #(.W(1)) u_cmp_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(adc_cmp_pin),
    .level(cmp_lvl)
  );

  gpl_pin_sync #(.W(NIB_W)) u_bidir_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(nibble_bidir_port_in),
    .level(bidir_lvl)
  );

  gpl_pin_sync #(.W(NIB_W)) u_in_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(input_only_port),
    .level(in_lvl)
  );

  // state
  logic ce_prev_r, ce_rst_r, dir_out_r, edge_fall_r;
  logic ce_prev_nxt, ce_rst_nxt, dir_out_nxt, edge_fall_nxt;
  logic [NIB_W-1:0] pp_r, odb_r, odc_r, bid_r, ref_r;
  logic [NIB_W-1:0] pp_nxt, odb_nxt, odc_nxt, bid_nxt, ref_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic [NIB_W-1:0] dm_rd_r, dm_rd_nxt, rf_rd_r, rf_rd_nxt;
  logic dm_hit_r, dm_hit_nxt, rf_hit_r, rf_hit_nxt;
  logic ce_rise;

  always_comb begin
    ce_prev_nxt = ce_lvl;
    ce_rise = ce_lvl & ~ce_prev_r;
    ce_rst_nxt = ce_rise;
    pp_nxt = pp_r;
    odb_nxt = odb_r;
    odc_nxt = odc_r;
    bid_nxt = bid_r;
    dir_out_nxt = dir_out_r;
    edge_fall_nxt = edge_fall_r;
    ref_nxt = ref_r;
    chan_nxt = chan_r;
    if (dm_req.we) begin
      if (dm_at(dm_req, BANK_2, ADDR_OD_B)) odb_nxt = dm_req.wdata;
      if (dm_at(dm_req, BANK_2, ADDR_OD_C)) odc_nxt = dm_req.wdata;
      if (dm_at(dm_req, BANK_0, ADDR_PP)) pp_nxt = dm_req.wdata;
      if (dm_at(dm_req, BANK_1, ADDR_BIDIR)) bid_nxt = dm_req.wdata;
    end
    if (rf_req.we) begin
      if (rf_req.addr == RF_DIR_ADDR) begin
        dir_out_nxt = rf_req.wdata[RF_DIR_BIT];
      end
      if (rf_req.addr == RF_EDGE_ADDR) begin
        edge_fall_nxt = rf_req.wdata[RF_EDGE_BIT];
      end
      if (rf_req.addr == RF_ADC_REF_ADDR) begin
        ref_nxt = rf_req.wdata;
      end
      if (rf_req.addr == RF_ADC_CHAN_ADDR) begin
        chan_nxt = rf_req.wdata[2:0];
      end
    end
    // clock stop and CE reset force input; CE reset also selects rising edge
    if (osc_stopped || ce_rise) begin
      dir_out_nxt = RST_DIR_OUT;
    end
    if (ce_rise) begin
      edge_fall_nxt = RST_EDGE_FALL;
    end
  end

  // reads: pins for inputs, latches for outputs
  always_comb begin
    dm_rd_nxt = RST_NIB;
    dm_hit_nxt = 1'b0;
    if (dm_req.re) begin
      dm_hit_nxt = 1'b1;
      if (dm_at(dm_req, BANK_2, ADDR_OD_B)) begin
        dm_rd_nxt = odb_r;
      end else if (dm_at(dm_req, BANK_2, ADDR_OD_C)) begin
        dm_rd_nxt = odc_r;
      end else if (dm_at(dm_req, BANK_0, ADDR_PP)) begin
        dm_rd_nxt = pp_r;
      end else if (dm_at(dm_req, BANK_1, ADDR_BIDIR)) begin
        dm_rd_nxt = dir_out_r ? bid_r : bidir_lvl;
      end else if (dm_at(dm_req, BANK_0, ADDR_IN)) begin
        dm_rd_nxt = in_lvl;
      end else begin
        dm_hit_nxt = 1'b0;
      end
    end
    rf_rd_nxt = RST_NIB;
    rf_hit_nxt = 1'b0;
    if (rf_req.re) begin
      rf_hit_nxt = 1'b1;
      unique case (rf_req.addr)
        RF_DIR_ADDR: rf_rd_nxt = {3'h0, dir_out_r};
        RF_EDGE_ADDR: rf_rd_nxt = {3'h0, edge_fall_r};
        RF_ADC_REF_ADDR: rf_rd_nxt = ref_r;
        RF_ADC_CHAN_ADDR: rf_rd_nxt = {1'b0, chan_r};
        RF_ADC_CMP_ADDR: rf_rd_nxt = {3'h0, cmp_lvl};
        default: rf_hit_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ce_prev_r <= 1'b0;
      ce_rst_r <= 1'b0;
      dir_out_r <= RST_DIR_OUT;
      edge_fall_r <= RST_EDGE_FALL;
      pp_r <= RST_NIB;
      odb_r <= RST_OD_LATCH;
      odc_r <= RST_OD_LATCH;
      bid_r <= RST_NIB;
      ref_r <= RST_NIB;
      chan_r <= 3'h0;
      dm_rd_r <= RST_NIB;
      dm_hit_r <= 1'b0;
      rf_rd_r <= RST_NIB;
      rf_hit_r <= 1'b0;
    end else begin
      ce_prev_r <= ce_prev_nxt;
      ce_rst_r <= ce_rst_nxt;
      dir_out_r <= dir_out_nxt;
      edge_fall_r <= edge_fall_nxt;
      pp_r <= pp_nxt;
      odb_r <= odb_nxt;
      odc_r <= odc_nxt;
      bid_r <= bid_nxt;
      ref_r <= ref_nxt;
      chan_r <= chan_nxt;
      dm_rd_r <= dm_rd_nxt;
      dm_hit_r <= dm_hit_nxt;
      rf_rd_r <= rf_rd_nxt;
      rf_hit_r <= rf_hit_nxt;
    end
  end

  gpl_rmc_edge u_rmc_edge (
    .mclk(mclk),
    .nrst(nrst),
    .level(rmc_lvl),
    .fall_sel(edge_fall_r),
    .irq(remote_ctl_irq)
  );

  // open drain: a zero bit pulls the pin low
  assign open_drain_out_port_b.out = RST_NIB;
  assign open_drain_out_port_b.oe = ~odb_r;
  assign open_drain_out_port_c.out = RST_NIB;
  assign open_drain_out_port_c.oe = ~odc_r;
  assign push_pull_out_port = pp_r;
  assign nibble_bidir_port.out = bid_r;
  assign nibble_bidir_port.oe = {NIB_W{dir_out_r}};
  assign dm_rdata = dm_rd_r;
  assign dm_hit = dm_hit_r;
  assign rf_rdata = rf_rd_r;
  assign rf_hit = rf_hit_r;
  assign adc_ref = ref_r;
  assign adc_chan = chan_r;
  assign ce_reset = ce_rst_r;

  a_od_b_write: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.we && dm_at(dm_req, BANK_2, ADDR_OD_B)
    |=> open_drain_out_port_b.oe == ~$past(dm_req.wdata))
    else $error("open-drain port b latch not written");

  a_od_c_write: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.we && dm_at(dm_req, BANK_2, ADDR_OD_C)
    |=> open_drain_out_port_c.oe == ~$past(dm_req.wdata))
    else $error("open-drain port c latch not written");

  a_pp_write: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.we && dm_at(dm_req, BANK_0, ADDR_PP)
    |=> push_pull_out_port == $past(dm_req.wdata))
    else $error("push-pull latch not written");

  a_bidir_whole: assert property (@(posedge mclk) disable iff (!nrst)
    nibble_bidir_port.oe == 4'h0 || nibble_bidir_port.oe == 4'hF)
    else $error("bidirectional port split direction");

  a_dir_write: assert property (@(posedge mclk) disable iff (!nrst)
    rf_req.we && rf_req.addr == RF_DIR_ADDR && !osc_stopped && !ce_rise
    |=> nibble_bidir_port.oe == {NIB_W{$past(rf_req.wdata[RF_DIR_BIT])}})
    else $error("direction bit not applied");

  a_bidir_latch: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.we && dm_at(dm_req, BANK_1, ADDR_BIDIR)
    |=> nibble_bidir_port.out == $past(dm_req.wdata))
    else $error("bidirectional latch not written");

  a_dir_forced: assert property (@(posedge mclk) disable iff (!nrst)
    osc_stopped || ce_rise |=> nibble_bidir_port.oe == 4'h0)
    else $error("bidirectional port not forced to input");

  a_ce_rst_out: assert property (@(posedge mclk) disable iff (!nrst)
    ce_rise |=> ce_reset)
    else $error("CE reset pulse missing");

  a_in_read: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.re && dm_at(dm_req, BANK_0, ADDR_IN)
    |=> dm_hit && dm_rdata == $past(in_lvl))
    else $error("input port read wrong");

  a_edge_reset: assert property (@(posedge mclk) disable iff (!nrst)
    ce_rise |=> !edge_fall_r)
    else $error("rising edge not selected after CE reset");

  a_edge_rise: assert property (@(posedge mclk) disable iff (!nrst)
    !edge_fall_r && $rose(rmc_lvl) |=> remote_ctl_irq)
    else $error("rising edge missed");

  a_edge_fall: assert property (@(posedge mclk) disable iff (!nrst)
    edge_fall_r && $fell(rmc_lvl) |=> remote_ctl_irq)
    else $error("falling edge missed");

  a_ce_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    ce_reset |=> !ce_reset)
    else $error("CE reset pulse too long");

  a_rmc_stable: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(rmc_lvl) |-> $past(u_rmc_sync.s2_r == u_rmc_sync.s3_r)
    && rmc_lvl == $past(u_rmc_sync.s3_r))
    else $error("remote level accepted without two samples");

  a_bidir_read: assert property (@(posedge mclk) disable iff (!nrst)
    dm_req.re && dm_at(dm_req, BANK_1, ADDR_BIDIR) && !dir_out_r
    |=> dm_rdata == $past(bidir_lvl))
    else $error("bidirectional input read wrong");

endmodule // gpl_top
`default_nettype wire

// [pkg/gpl_pkg.sv]
package gpl_pkg;

  localparam int NIB_W = 4;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 7;

  // data-memory banks and port latch locations
  localparam logic [BANK_W-1:0] BANK_0 = 4'h0;
  localparam logic [BANK_W-1:0] BANK_1 = 4'h1;
  localparam logic [BANK_W-1:0] BANK_2 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OD_B = 7'h71;
  localparam logic [ADDR_W-1:0] ADDR_OD_C = 7'h72;
  localparam logic [ADDR_W-1:0] ADDR_PP = 7'h72;
  localparam logic [ADDR_W-1:0] ADDR_BIDIR = 7'h72;
  localparam logic [ADDR_W-1:0] ADDR_IN = 7'h73;

  // register-file locations
  localparam logic [ADDR_W-1:0] RF_DIR_ADDR = 7'h27;
  localparam int RF_DIR_BIT = 0;
  localparam logic [ADDR_W-1:0] RF_EDGE_ADDR = 7'h2A;
  localparam int RF_EDGE_BIT = 0;
  localparam logic [ADDR_W-1:0] RF_ADC_REF_ADDR = 7'h2B;
  localparam logic [ADDR_W-1:0] RF_ADC_CHAN_ADDR = 7'h2C;
  localparam logic [ADDR_W-1:0] RF_ADC_CMP_ADDR = 7'h2D;

  // values after reset
  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [NIB_W-1:0] RST_OD_LATCH = 4'hF;
  localparam logic RST_DIR_OUT = 1'b0;
  localparam logic RST_EDGE_FALL = 1'b0;

  typedef struct packed {
    logic we;
    logic re;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] wdata;
  } gpl_dm_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] wdata;
  } gpl_rf_req_t;

  typedef struct packed {
    logic [NIB_W-1:0] out;
    logic [NIB_W-1:0] oe;
  } gpl_pin_t;

endpackage

// [hw/gpl_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module gpl_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pin side
  input wire logic [W-1:0] pin,
  // accepted level
  output logic [W-1:0] level
);
  import gpl_pkg::*;

  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [W-1:0] lvl_nxt;

  // a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;
endmodule // gpl_pin_sync
`default_nettype wire

// [hw/gpl_rmc_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module gpl_rmc_edge (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // filtered level and edge choice
  input wire logic level,
  input wire logic fall_sel,
  // request pulse
  output logic irq
);
  import gpl_pkg::*;

  logic prev_r, irq_r;
  logic prev_nxt, irq_nxt;

  always_comb begin
    prev_nxt = level;
    irq_nxt = fall_sel ? (prev_r & ~level) : (~prev_r & level);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;
endmodule // gpl_rmc_edge
`default_nettype wire

// [verification/gpl_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gpl_cpu_model (
  // clock
  input wire logic mclk,
  // requests to the port block
  output var gpl_pkg::gpl_dm_req_t dm_req,
  output var gpl_pkg::gpl_rf_req_t rf_req,
  // answers
  input wire logic [gpl_pkg::NIB_W-1:0] dm_rdata,
  input wire logic dm_hit,
  input wire logic [gpl_pkg::NIB_W-1:0] rf_rdata,
  input wire logic rf_hit
);
  import gpl_pkg::*;

  initial begin
    dm_req = '0;
    rf_req = '0;
  end

  // request held from falling edge through the taking edge
  task automatic dm_acc(input logic we, input logic [BANK_W-1:0] bank,
                        input logic [ADDR_W-1:0] addr,
                        input logic [NIB_W-1:0] wdata,
                        output logic [NIB_W-1:0] rdata, output logic hit);
    @(negedge mclk);
    dm_req = '{we: we, re: ~we, bank: bank, addr: addr, wdata: wdata};
    @(posedge mclk);
    @(negedge mclk);
    dm_req = '0;
    rdata = dm_rdata;
    hit = dm_hit;
  endtask

  task automatic rf_acc(input logic we, input logic [ADDR_W-1:0] addr,
                        input logic [NIB_W-1:0] wdata,
                        output logic [NIB_W-1:0] rdata, output logic hit);
    @(negedge mclk);
    rf_req = '{we: we, re: ~we, addr: addr, wdata: wdata};
    @(posedge mclk);
    @(negedge mclk);
    rf_req = '0;
    rdata = rf_rdata;
    hit = rf_hit;
  endtask
endmodule // gpl_cpu_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpl_pkg::*;
  logic mclk, nrst, ce_pin, osc_stopped, adc_cmp_pin, remote_ctl_irq_in;
  logic [NIB_W-1:0] nibble_bidir_port_in, input_only_port;
  logic [NIB_W-1:0] dm_rdata, rf_rdata, push_pull_out_port, adc_ref, rd;
  logic dm_hit, rf_hit, ce_reset, remote_ctl_irq, hit, seen;
  logic [2:0] adc_chan;
  gpl_dm_req_t dm_req;
  gpl_rf_req_t rf_req;
  gpl_pin_t od_b, od_c, bidir;
  int fail_count, total_checks, cycles;

  gpl_top gpl_top_inst (.mclk(mclk), .nrst(nrst), .ce_pin(ce_pin),
    .osc_stopped(osc_stopped), .ce_reset(ce_reset), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .dm_hit(dm_hit), .rf_req(rf_req),
    .rf_rdata(rf_rdata), .rf_hit(rf_hit),
    .push_pull_out_port(push_pull_out_port),
    .open_drain_out_port_b(od_b), .open_drain_out_port_c(od_c),
    .nibble_bidir_port_in(nibble_bidir_port_in),
    .nibble_bidir_port(bidir), .input_only_port(input_only_port),
    .adc_cmp_pin(adc_cmp_pin), .adc_ref(adc_ref), .adc_chan(adc_chan),
    .remote_ctl_irq_in(remote_ctl_irq_in),
    .remote_ctl_irq(remote_ctl_irq));

  gpl_cpu_model gpl_cpu_model_inst (.mclk(mclk), .dm_req(dm_req),
    .rf_req(rf_req), .dm_rdata(dm_rdata), .dm_hit(dm_hit),
    .rf_rdata(rf_rdata), .rf_hit(rf_hit));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 3000) begin
      fail_count++;
      close_out();
    end
  end

  task dm(input logic we, input logic [3:0] bank, input logic [6:0] addr,
          input logic [3:0] wdata);
    gpl_cpu_model_inst.dm_acc(we, bank, addr, wdata, rd, hit);
  endtask

  task rf(input logic we, input logic [6:0] addr, input logic [3:0] wdata);
    gpl_cpu_model_inst.rf_acc(we, addr, wdata, rd, hit);
  endtask

  task t_reset;
    check(od_b.oe, 8'h00);
    check(od_c.oe, 8'h00);
    check(bidir.oe, 8'h00);
    dm(1'b0, BANK_2, ADDR_OD_B, 4'h0);
    check({hit, rd}, 8'h1F);
  endtask

  task t_latches;
    dm(1'b1, BANK_2, ADDR_OD_B, 4'h5);
    check(od_b.oe, 8'h0A);
    dm(1'b1, BANK_2, ADDR_OD_C, 4'h3);
    check({od_c.out, od_c.oe}, 8'h0C);
    dm(1'b1, BANK_0, ADDR_PP, 4'h9);
    check(push_pull_out_port, 8'h09);
    check(od_c.oe, 8'h0C);
    dm(1'b1, BANK_1, ADDR_BIDIR, 4'h6);
    check(bidir.out, 8'h06);
    dm(1'b0, BANK_0, ADDR_PP, 4'h0);
    check({hit, rd}, 8'h19);
    dm(1'b0, BANK_2, ADDR_OD_C, 4'h0);
    check({hit, rd}, 8'h13);
    dm(1'b1, 4'h3, ADDR_PP, 4'h0);
    check(push_pull_out_port, 8'h09);
    dm(1'b0, 4'h3, ADDR_PP, 4'h0);
    check({hit, rd}, 8'h00);
  endtask

  task t_inputs;
    @(negedge mclk);
    input_only_port = 4'hB;
    nibble_bidir_port_in = 4'hD;
    repeat (6) @(negedge mclk);
    dm(1'b0, BANK_0, ADDR_IN, 4'h0);
    check({hit, rd}, 8'h1B);
    dm(1'b0, BANK_1, ADDR_BIDIR, 4'h0);
    check(rd, 8'h0D);
    rf(1'b1, RF_DIR_ADDR, 4'h1);
    check(bidir.oe, 8'h0F);
    dm(1'b0, BANK_1, ADDR_BIDIR, 4'h0);
    check(rd, 8'h06);
    rf(1'b1, RF_DIR_ADDR, 4'hE);
    check(bidir.oe, 8'h00);
    rf(1'b1, RF_DIR_ADDR, 4'h1);
    osc_stopped = 1'b1;
    repeat (2) @(negedge mclk);
    osc_stopped = 1'b0;
    check(bidir.oe, 8'h00);
  endtask

  task t_ce;
    rf(1'b1, RF_DIR_ADDR, 4'h1);
    rf(1'b1, RF_EDGE_ADDR, 4'h1);
    ce_pin = 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      if (ce_reset === 1'b1)
        seen = 1'b1;
    end
    check(seen, 8'h01);
    check(bidir.oe, 8'h00);
    rf(1'b0, RF_EDGE_ADDR, 4'h0);
    check({hit, rd}, 8'h10);
  endtask

  task irq_cnt(input logic lvl, input int len, input int exp);
    int n;
    n = 0;
    remote_ctl_irq_in = lvl;
    for (int i = 0; i < 12; i++) begin
      @(negedge mclk);
      if (i == len - 1)
        remote_ctl_irq_in = ~lvl;
      if (remote_ctl_irq === 1'b1)
        n++;
    end
    check(n[7:0], exp[7:0]);
  endtask

  task t_irq;
    irq_cnt(1'b1, 0, 1);
    irq_cnt(1'b0, 0, 0);
    irq_cnt(1'b1, 1, 0);
    rf(1'b1, RF_EDGE_ADDR, 4'h1);
    irq_cnt(1'b1, 0, 0);
    irq_cnt(1'b0, 0, 1);
  endtask

  task t_adc;
    rf(1'b1, RF_DIR_ADDR, 4'h0);
    rf(1'b1, RF_ADC_REF_ADDR, 4'h7);
    check(adc_ref, 8'h07);
    rf(1'b1, RF_ADC_CHAN_ADDR, 4'h5);
    check(adc_chan, 8'h05);
    adc_cmp_pin = 1'b1;
    repeat (5) @(negedge mclk);
    rf(1'b0, RF_ADC_CMP_ADDR, 4'h0);
    check(rd[0], 8'h01);
  endtask

  initial begin
    nrst = 1'b0;
    ce_pin = 1'b0;
    osc_stopped = 1'b0;
    adc_cmp_pin = 1'b0;
    remote_ctl_irq_in = 1'b0;
    nibble_bidir_port_in = 4'h0;
    input_only_port = 4'h0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_reset();
    t_latches();
    t_inputs();
    t_ce();
    t_irq();
    t_adc();
    close_out();
  end
endmodule // testbench
`default_nettype wire
